// *** shared/mode0_cfg_regs.svh ***
// register offsets, field positions and reset values of the mode-0 configuration bank
// Behaviour
// - ship request bit set while mode setting 0 active puts device in ship mode
// - source select 0: mode comes from the two internal soft bits only
// - source select 1: mode comes from the two external select pins only
// - core buck code 0 is 0.500 V, plus 25 mV per step to 1.500 V
// - core buck codes 41..62 give 1.5 V; all-ones selects fixed 1.8 V
// - core buck code resets to 010100, meaning 1.00 V
// - wake action 0: valid wake falling edge returns device to mode setting 0
// - wake action 1: valid wake falling edge causes no mode change
// - system buck offset bit adds 0 V or 1.2 V; resets to 0
// - system buck code 0 is 1.500 V, 25 mV steps, saturating at 2.1 V
// - system buck code resets to 01100, meaning 1.8 V
`ifndef MODE0_CFG_REGS_SVH
`define MODE0_CFG_REGS_SVH
`define OFS_MODE0_CORE_BUCK_AND_CONTROL 8'h22
`define OFS_MODE0_SYSTEM_BUCK_AND_WAKE  8'h23
`define BIT_SHIP_REQ       7
`define BIT_SRC_PIN_SEL    6
`define BIT_WAKE_ACTION    6
`define BIT_SYS_OFFSET     5
`define RST_CORE_BUCK_CODE 6'h14
`define RST_SYS_BUCK_CODE  5'h0C
`define RST_CTRL_BITS      1'h0
`define CORE_MV_BASE       16'h01F4
`define SYS_MV_BASE        16'h05DC
`define MV_STEP            16'h0019
`define CORE_CODE_MAX      6'h28
`define CORE_CODE_FIXED    6'h3F
`define CORE_MV_FIXED      16'h0708
`define SYS_CODE_MAX       5'h18
`define SYS_MV_OFFSET      16'h04B0
`endif

// *** shared/mode0_cfg_pkg.sv ***
// types shared by the mode-0 configuration bank
package mode0_cfg_pkg;
    // byte-wide register access from the serial interface core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
    // settings that the mode engine applies while mode 0 is active
    typedef struct packed {
        logic        ship_mode;
        logic [15:0] core_buck_mv;
        logic [15:0] sys_buck_mv;
        logic [1:0]  mode_sel;
    } mode0_out_s;
endpackage

// *** hdl/mode0_regulator_config_regs.sv ***
// mode-0 regulator configuration register bank with mode-source and wake decisions
`timescale 1ns/1ps
`include "mode0_cfg_regs.svh"
module mode0_regulator_config_regs
    import mode0_cfg_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // register access from the serial interface core
    input  wire reg_req_s   req,
    output logic [7:0]      rdata,
    output logic            rvalid,
    // mode state and pins
    input  wire logic       mode0_active,
    input  wire logic       mode_select_pin_a,
    input  wire logic       mode_select_pin_b,
    input  wire logic       mode_select_soft_bit_a,
    input  wire logic       mode_select_soft_bit_b,
    input  wire logic       wake_fall_valid,
    // decisions towards the mode engine and regulators
    output mode0_out_s      cfg_out,
    output logic            cfg_valid,
    output logic            wake_to_mode0
);

    logic       ship_q, ship_d;
    logic       src_q, src_d;
    logic [5:0] core_q, core_d;
    logic       rsvd_q, rsvd_d;
    logic       wake_act_q, wake_act_d;
    logic       ofs_q, ofs_d;
    logic [4:0] sys_q, sys_d;
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;
    logic [1:0] pin_a_q, pin_b_q;
    mode0_out_s out_q, out_d;
    logic       valid_q, valid_d;
    logic       wake_q, wake_d;

    // core buck code to millivolts
    function automatic logic [15:0] core_mv(input logic [5:0] code);
        if (code == `CORE_CODE_FIXED)
            core_mv = `CORE_MV_FIXED;
        else if (code > `CORE_CODE_MAX)
            core_mv = `CORE_MV_BASE + `MV_STEP * {10'h000, `CORE_CODE_MAX};
        else
            core_mv = `CORE_MV_BASE + `MV_STEP * {10'h000, code};
    endfunction

    // system buck code plus offset to millivolts
    function automatic logic [15:0] sys_mv(input logic [4:0] code, input logic ofs);
        logic [4:0] c;
        c = (code > `SYS_CODE_MAX) ? `SYS_CODE_MAX : code;
        sys_mv = `SYS_MV_BASE + `MV_STEP * {11'h000, c} + (ofs ? `SYS_MV_OFFSET : 16'h0000);
    endfunction

    // register writes and read data
    always_comb begin
        ship_d     = ship_q;
        src_d      = src_q;
        core_d     = core_q;
        rsvd_d     = rsvd_q;
        wake_act_d = wake_act_q;
        ofs_d      = ofs_q;
        sys_d      = sys_q;
        rdata_d    = rdata_q;
        rvalid_d   = req.rd;
        if (req.wr) begin
            case (req.addr)
                `OFS_MODE0_CORE_BUCK_AND_CONTROL: begin
                    ship_d = req.wdata[`BIT_SHIP_REQ];
                    src_d  = req.wdata[`BIT_SRC_PIN_SEL];
                    core_d = req.wdata[5:0];
                end
                `OFS_MODE0_SYSTEM_BUCK_AND_WAKE: begin
                    rsvd_d     = req.wdata[7]; // kept read/write; host is expected to write 0
                    wake_act_d = req.wdata[`BIT_WAKE_ACTION];
                    ofs_d      = req.wdata[`BIT_SYS_OFFSET];
                    sys_d      = req.wdata[4:0];
                end
                default: ;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                `OFS_MODE0_CORE_BUCK_AND_CONTROL: rdata_d = {ship_q, src_q, core_q};
                `OFS_MODE0_SYSTEM_BUCK_AND_WAKE:  rdata_d = {rsvd_q, wake_act_q, ofs_q, sys_q};
                default:                          rdata_d = 8'h00; // unmapped reads as zero
            endcase
        end
    end

    // decisions, evaluated each cycle so a write lands on the next evaluation
    always_comb begin
        out_d              = out_q;
        out_d.ship_mode    = mode0_active & ship_q;
        out_d.core_buck_mv = core_mv(core_q);
        out_d.sys_buck_mv  = sys_mv(sys_q, ofs_q);
        if (src_q)
            out_d.mode_sel = {pin_b_q[1], pin_a_q[1]};
        else
            out_d.mode_sel = {mode_select_soft_bit_b, mode_select_soft_bit_a};
        valid_d = mode0_active;
        // already in mode 0 means no switch; action bit set means stay put
        wake_d  = wake_fall_valid & ~wake_act_q & ~mode0_active;
    end

    // state registers; pins pass a two-stage synchroniser first
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ship_q     <= `RST_CTRL_BITS;
            src_q      <= `RST_CTRL_BITS;
            core_q     <= `RST_CORE_BUCK_CODE;
            rsvd_q     <= `RST_CTRL_BITS;
            wake_act_q <= `RST_CTRL_BITS;
            ofs_q      <= `RST_CTRL_BITS;
            sys_q      <= `RST_SYS_BUCK_CODE;
            rdata_q    <= 8'h00;
            rvalid_q   <= 1'b0;
            pin_a_q    <= 2'h0;
            pin_b_q    <= 2'h0;
            out_q      <= '0;
            valid_q    <= 1'b0;
            wake_q     <= 1'b0;
        end else begin
            ship_q     <= ship_d;
            src_q      <= src_d;
            core_q     <= core_d;
            rsvd_q     <= rsvd_d;
            wake_act_q <= wake_act_d;
            ofs_q      <= ofs_d;
            sys_q      <= sys_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
            pin_a_q    <= {pin_a_q[0], mode_select_pin_a};
            pin_b_q    <= {pin_b_q[0], mode_select_pin_b};
            out_q      <= out_d;
            valid_q    <= valid_d;
            wake_q     <= wake_d;
        end
    end

    assign rdata         = rdata_q;
    assign rvalid        = rvalid_q;
    assign cfg_out       = out_q;
    assign cfg_valid     = valid_q;
    assign wake_to_mode0 = wake_q;

endmodule

// *** dv/mode0_cfg_chk.sv ***
// port assertions for the mode-0 configuration bank
`timescale 1ns/1ps
module mode0_cfg_chk
    import mode0_cfg_pkg::*;
(
    // watched ports
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire reg_req_s   req,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    input wire logic       mode0_active,
    input wire logic       wake_fall_valid,
    input wire mode0_out_s cfg_out,
    input wire logic       cfg_valid,
    input wire logic       wake_to_mode0
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // all-ones core code written, no write right behind it
    sequence s_fixed;
        req.wr && req.addr == 8'h22 && req.wdata[5:0] == 6'h3F ##1 !req.wr;
    endsequence
    a_read_ack: assert property (req.rd |=> rvalid)
        else $error("no read ack");
    a_read_unmapped: assert property
        (req.rd && !(req.addr inside {8'h22, 8'h23}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property
        ($past(reset_n) && !$past(req.rd) |-> $stable(rdata))
        else $error("rdata moved");
    a_ship_gate: assert property (cfg_out.ship_mode |-> $past(mode0_active))
        else $error("ship outside mode 0");
    a_valid_follow: assert property
        ($past(reset_n) |-> cfg_valid == $past(mode0_active))
        else $error("cfg_valid wrong");
    a_wake_cause: assert property
        (wake_to_mode0 |-> $past(wake_fall_valid && !mode0_active))
        else $error("wake without cause");
    a_wake_refused: assert property (mode0_active && wake_fall_valid |=> !wake_to_mode0)
        else $error("wake in mode 0");
    a_core_fixed: assert property (s_fixed |=> cfg_out.core_buck_mv == 16'h0708)
        else $error("fixed code not 1800");
endmodule
bind mode0_regulator_config_regs mode0_cfg_chk i_chk (.ref_clk, .reset_n, .req, .rdata,
    .rvalid, .mode0_active, .wake_fall_valid, .cfg_out, .cfg_valid, .wake_to_mode0);

// *** dv/host_model.sv ***
// host model issuing single-byte register transfers
`timescale 1ns/1ps
module host_model
    import mode0_cfg_pkg::*;
(
    input  wire logic [7:0] rdata,
    input  wire logic       ref_clk,
    output reg_req_s        req
);
    initial req = '0;
    // one-cycle strobe; address and data are driven inverted after release
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge ref_clk);
        req = '{w, !w, a, d};
        @(negedge ref_clk);
        q = rdata;
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the mode-0 configuration bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top
    import mode0_cfg_pkg::*;
;
    logic       ref_clk, reset_n, m0, wfv, pa, pb, sa, sb, cv, w2m, rv;
    logic [7:0] rdata, q, r22, r23;
    logic [31:0] v;
    reg_req_s   req;
    mode0_out_s cfg_out;
    int         miscompares, n_tests, seed = 24;
    host_model i_host (.rdata, .ref_clk, .req);
    mode0_regulator_config_regs i_dut (.ref_clk, .reset_n, .req, .rdata, .rvalid(rv),
        .mode0_active(m0), .mode_select_pin_a(pa), .mode_select_pin_b(pb),
        .mode_select_soft_bit_a(sa), .mode_select_soft_bit_b(sb), .wake_fall_valid(wfv),
        .cfg_out, .cfg_valid(cv), .wake_to_mode0(w2m));
    // reference millivolts; codes 41..62 saturate at the top step, all-ones gives 1800
    function automatic int core_mv(int c);
        return c == 63 ? 1800 : 500 + 25 * (c > 40 ? 40 : c);
    endfunction
    task automatic give_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    // the whole run needs about 730 cycles
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
    initial begin
        {reset_n, m0, wfv, pa, pb, sa, sb} = '0;
        repeat (16) @(negedge ref_clk);
        reset_n = 1;
        @(negedge ref_clk);
        `CHK("sys", 1800, cfg_out.sys_buck_mv)
        i_host.xfer(0, 8'h22, 0, q);
        `CHK("rd22", 8'h14, q)
        i_host.xfer(0, 8'h24, 0, q);
        `CHK("rd24", 8'h00, q)
        // every core code once and every system code twice, with random control bits and mode inputs
        for (int i = 0; i < 64; i++) begin
            v = $random(seed);
            {m0, pa, pb, sa, sb} = v[12:8];
            r22 = {v[7:6], 6'(i)};
            r23 = {1'b0, v[14:13], 5'(i)};
            i_host.xfer(1, 8'h22, r22, q);
            i_host.xfer(1, 8'h23, r23, q);
            repeat (4) @(negedge ref_clk);
            `CHK("core", core_mv(i), cfg_out.core_buck_mv)
            `CHK("sys", 1500 + 25 * (i % 32 > 24 ? 24 : i % 32) + 1200 * r23[5], cfg_out.sys_buck_mv)
            `CHK("ship", r22[7] & m0, cfg_out.ship_mode)
            `CHK("valid", m0, cv)
            `CHK("sel", r22[6] ? {pb, pa} : {sb, sa}, cfg_out.mode_sel)
            i_host.xfer(0, 8'h23, 0, q);
            `CHK("rd23", r23, q)
            wfv = 1;
            @(negedge ref_clk);
            wfv = 0;
            `CHK("wake", !r23[6] & !m0, w2m)
        end
        give_verdict();
    end
endmodule
